// *** lbbc_div_if.sv ***
// Purpose: carries dead-time and top frequency between modules
// Assumes: one clock domain
// Notes:   req is a level; done is high for one cycle
`timescale 1ns/1ns
`default_nettype none
interface lbbc_div_if;
  logic        req;
  logic [9:0]  divisor;
  logic        done;
  logic [10:0] quotient;
  modport master (output req, output divisor,
                  input done, input quotient);
  modport slave  (input req, input divisor,
                  output done, output quotient);
endinterface : lbbc_div_if
`default_nettype wire

// *** lbbc_freq_div.sv ***
// Purpose: top switch frequency from dead-time, by serial division
// Assumes: divisor stable while a division runs
// Notes:   saturates at 11 bits; zero divisor saturates
`timescale 1ns/1ns
`default_nettype none
module lbbc_freq_div (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  lbbc_div_if.slave   dv
);
  typedef struct packed {
    logic        busy;
    logic [4:0]  step;
    logic [10:0] rem;
    logic [18:0] quo;
    logic [9:0]  dvsr;
    logic        done;
    logic [10:0] result;
  } lbbc_div_state_type;

  lbbc_div_state_type q_r, q_nxt;
  logic [10:0] trial;

  // ==========================================================
  // restoring division of the fixed product
  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    trial = {q_r.rem[9:0], q_r.quo[18]};
    if (!q_r.busy) begin
      if (dv.req) begin
        q_nxt.busy = 1'b1;
        q_nxt.step = 5'h00;
        q_nxt.rem  = 11'h000;
        q_nxt.quo  = lbbc_pkg::DEADTIME_PRODUCT;
        q_nxt.dvsr = dv.divisor;
      end
    end else begin
      q_nxt.rem = trial;
      q_nxt.quo = {q_r.quo[17:0], 1'b0};
      if (trial >= {1'b0, q_r.dvsr}) begin
        q_nxt.rem    = trial - {1'b0, q_r.dvsr};
        q_nxt.quo[0] = 1'b1;
      end
      q_nxt.step = q_r.step + 5'h01;
      if (q_r.step == 5'h12) begin
        q_nxt.busy = 1'b0;
        q_nxt.done = 1'b1;
        if (q_r.dvsr == 10'h000 || q_nxt.quo[18:11] != 8'h00) begin
          q_nxt.result = lbbc_pkg::TOP_KHZ_SAT;
        end else begin
          q_nxt.result = q_nxt.quo[10:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign dv.done     = q_r.done;
  assign dv.quotient = q_r.result;

  // ==========================================================
  quotient_exact_a: assert property (@(posedge clk_sys) disable iff (rst)
    (q_r.done && q_r.dvsr != 10'h000 && q_r.result != 11'h7ff) |->
      ({8'h00, q_r.result} * q_r.dvsr <= 29'd270000 &&
       ({8'h00, q_r.result} + 19'h1) * q_r.dvsr > 29'd270000))
    else $error("top frequency not product over dead-time");
endmodule : lbbc_freq_div
`default_nettype wire

// *** lbbc_pkg.sv ***
// Purpose: constants for the burst and brown-out control block
// Assumes: clk_sys at 10 MHz; input level code in 10 mV steps
// Notes:   fractions of the top switch frequency are in sixteenths
// Functional notes
// - switch only after brown-in; brown-out at 79%
// - overvoltage lock above 131%, release below 126%
// - stop half-bridge when level decays to brown-out
// - hold select input sensing 500 us after power-up
// - divider ratio 19/9/5.67 picks setting 1/2/3
// - setting latched until supply removed
// - after detection select input runs normal mode
// - top frequency kHz equals 270000 over dead-time ns
// - resume/halt sixteenths 7/8, 6/7, 5/6 per setting
// - halt at halt frequency, resume at resume frequency
// - start-up mode spans halt to top, exits below halt
// - delay counters tick at top switch frequency
// - 1024 ticks outputs off, soft-start pull after power-up
// - 131072 ticks outputs off after fault before retry
package lbbc_pkg;
  // ==========================================================
  // clock and times
  localparam int SYS_CLK_KHZ     = 10000;
  localparam int SENSE_TIME_US   = 500;
  localparam int SENSE_CYCLES    = SENSE_TIME_US * SYS_CLK_KHZ / 1000;
  localparam int PWRUP_TICKS     = 1024;
  localparam int RESTART_TICKS   = 131072;
  localparam int MIN_DEADTIME_NS = 275;
  localparam int MAX_TOP_KHZ     = 1000;
  // ==========================================================
  // input level thresholds, percent of brown-in
  localparam int BROWNIN_CODE   = 240;
  localparam int BROWNOUT_PCT   = 79;
  localparam int OV_TRIP_PCT    = 131;
  localparam int OV_RESTART_PCT = 126;
  localparam logic [9:0] BROWNOUT_CODE   =
    10'(BROWNIN_CODE * BROWNOUT_PCT / 100);
  localparam logic [9:0] OV_TRIP_CODE    =
    10'(BROWNIN_CODE * OV_TRIP_PCT / 100);
  localparam logic [9:0] OV_RESTART_CODE =
    10'(BROWNIN_CODE * OV_RESTART_PCT / 100);
  localparam logic [9:0] BROWNIN_LVL     = 10'(BROWNIN_CODE);
  // ==========================================================
  // select divider ratios (x100) and per-mille pin level
  localparam int RATIO1_X100 = 1900;
  localparam int RATIO2_X100 = 900;
  localparam int RATIO3_X100 = 567;
  localparam int RATIO_TOL_PM = 20;
  localparam int PM1 = 1000 * RATIO1_X100 / (RATIO1_X100 + 100);
  localparam int PM2 = 1000 * RATIO2_X100 / (RATIO2_X100 + 100);
  localparam int PM3 = 1000 * RATIO3_X100 / (RATIO3_X100 + 100);
  // ==========================================================
  // frequency relation and burst fractions
  localparam logic [18:0] DEADTIME_PRODUCT = 19'd270000;
  localparam logic [10:0] TOP_KHZ_SAT      = 11'h7ff;
  localparam logic [1:0]  SETTING_1 = 2'h1;
  localparam logic [1:0]  SETTING_2 = 2'h2;
  localparam logic [1:0]  SETTING_3 = 2'h3;
  localparam logic [4:0]  HALT16_S1   = 5'h08;
  localparam logic [4:0]  HALT16_S2   = 5'h07;
  localparam logic [4:0]  HALT16_S3   = 5'h06;
  localparam logic [4:0]  RESUME16_S1 = 5'h07;
  localparam logic [4:0]  RESUME16_S2 = 5'h06;
  localparam logic [4:0]  RESUME16_S3 = 5'h05;
  // ==========================================================
  typedef enum logic [2:0] {
    LBBC_SENSE   = 3'b000,
    LBBC_PWRDLY  = 3'b001,
    LBBC_WAITLVL = 3'b010,
    LBBC_RUN     = 3'b011,
    LBBC_RESTART = 3'b100
  } lbbc_state_type;
endpackage : lbbc_pkg

// *** lbbc_stage_model.sv ***
// Purpose: power stage, divider and feedback networks seen by the block
// Assumes: set points come from the bench, outputs move 1 ns after edge
// Notes:   divider reading is garbage once the select pin leaves sensing
`timescale 1ns/1ns
`default_nettype none
module lbbc_stage_model (
  input  wire logic       clk_sys,
  input  wire logic       selectSensing,
  input  wire logic       softStartPull,
  input  wire logic [9:0] busLevel,
  input  wire logic [9:0] ratioPm,
  input  wire logic [9:0] dtNs,
  input  wire logic [7:0] loopCmd,
  input  wire logic       isFault,
  output logic      [9:0] inputLevelCode,
  output logic      [9:0] selectLevelPm,
  output logic      [9:0] deadtimeNs,
  output logic      [7:0] cmdFrac256,
  output logic            currentFault
);
  // ==========================================================
  // analog levels
  initial begin
    inputLevelCode = 10'h0;
    selectLevelPm  = 10'h0;
    deadtimeNs     = 10'h12c;
    cmdFrac256     = 8'hff;
    currentFault   = 1'b0;
  end

  always @(posedge clk_sys) begin
    #1;
    inputLevelCode <= busLevel;
    // pin sinks current in normal mode, ratio no longer readable
    selectLevelPm  <= selectSensing ? ratioPm : ~selectLevelPm;
    deadtimeNs     <= (dtNs < 10'h113) ? 10'h113 : dtNs;
    // discharged soft-start cap commands the top frequency
    cmdFrac256     <= softStartPull ? 8'hff : loopCmd;
    currentFault   <= isFault;
  end
endmodule : lbbc_stage_model
`default_nettype wire

// *** lbbc_top.sv ***
// Purpose: brown-in/out, overvoltage, burst select and burst control
// Assumes: analog words digitised outside, slowly varying
// Notes:   rst is supply power-up; delay counters tick at top frequency, sense counter at clk_sys
`timescale 1ns/1ns
`default_nettype none
module lbbc_top #(
  parameter int SENSE_CYCLES  = lbbc_pkg::SENSE_CYCLES,
  parameter int PWRUP_TICKS   = lbbc_pkg::PWRUP_TICKS,
  parameter int RESTART_TICKS = lbbc_pkg::RESTART_TICKS
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [9:0] inputLevelCode,
  input  wire logic [9:0] selectLevelPm,
  input  wire logic [9:0] deadtimeNs,
  input  wire logic [7:0] cmdFrac256,
  input  wire logic       currentFault,
  output logic            bridgeEnable,
  output logic            softStartPull,
  output logic            selectSensing,
  output logic [1:0]      burstSetting,
  output logic [10:0]     topSwitchKhz,
  output logic [4:0]      haltFrac16,
  output logic [4:0]      resumeFrac16,
  output logic            startupMode,
  output logic            faultRestart
);
  typedef struct packed {
    logic [9:0]  lvl1, lvl2, sel1, sel2, dt1, dt2;
    logic [7:0]  cmd1, cmd2;
    logic        cs1, cs2;
    lbbc_pkg::lbbc_state_type st;
    logic [17:0] cnt;
    logic [13:0] acc;
    logic        levelOk, ovLock, startup, burstOff;
    logic [1:0]  setting;
    logic [10:0] topKhz;
  } lbbc_top_state_type;

  lbbc_top_state_type s_r, s_nxt;
  lbbc_div_if dvIf ();
  logic [14:0] accSum;
  logic        tick;
  logic [8:0]  haltCmp, resumeCmp;

  // ==========================================================
  // elaboration check
  if (SENSE_CYCLES < 1 || PWRUP_TICKS < 1 || RESTART_TICKS < 1 ||
      SENSE_CYCLES > 262143 || RESTART_TICKS > 262143 ||
      PWRUP_TICKS > 262143) begin : g_bad_param
    $error("lbbc_top: count parameter out of range");
  end

  lbbc_freq_div u_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .dv      (dvIf.slave)
  );
  assign dvIf.req     = (s_r.st != lbbc_pkg::LBBC_SENSE);
  assign dvIf.divisor = s_r.dt2;

  // ==========================================================
  // tick generator at the top switch frequency
  assign accSum = {1'b0, s_r.acc} + {4'h0, s_r.topKhz};
  assign tick = (accSum >= 15'(lbbc_pkg::SYS_CLK_KHZ));

  // sixteenths scaled to the 1/256 command grid
  assign haltCmp   = {haltFrac16, 4'h0};
  assign resumeCmp = {resumeFrac16, 4'h0};

  always_comb begin
    case (s_r.setting)
      lbbc_pkg::SETTING_2: begin
        haltFrac16   = lbbc_pkg::HALT16_S2;
        resumeFrac16 = lbbc_pkg::RESUME16_S2;
      end
      lbbc_pkg::SETTING_3: begin
        haltFrac16   = lbbc_pkg::HALT16_S3;
        resumeFrac16 = lbbc_pkg::RESUME16_S3;
      end
      default: begin
        haltFrac16   = lbbc_pkg::HALT16_S1;
        resumeFrac16 = lbbc_pkg::RESUME16_S1;
      end
    endcase
  end

  // ==========================================================
  // main control
  always_comb begin
    s_nxt = s_r;
    s_nxt.lvl1 = inputLevelCode;
    s_nxt.lvl2 = s_r.lvl1;
    s_nxt.sel1 = selectLevelPm;
    s_nxt.sel2 = s_r.sel1;
    s_nxt.dt1  = deadtimeNs;
    s_nxt.dt2  = s_r.dt1;
    s_nxt.cmd1 = cmdFrac256;
    s_nxt.cmd2 = s_r.cmd1;
    s_nxt.cs1  = currentFault;
    s_nxt.cs2  = s_r.cs1;
    s_nxt.acc  = tick ? 14'(accSum - 15'(lbbc_pkg::SYS_CLK_KHZ))
                      : accSum[13:0];
    if (dvIf.done) begin
      s_nxt.topKhz = dvIf.quotient;
    end
    // level qualifiers with hysteresis
    if (s_r.lvl2 >= lbbc_pkg::BROWNIN_LVL) begin
      s_nxt.levelOk = 1'b1;
    end else if (s_r.lvl2 < lbbc_pkg::BROWNOUT_CODE) begin
      s_nxt.levelOk = 1'b0;
    end
    if (s_r.lvl2 > lbbc_pkg::OV_TRIP_CODE) begin
      s_nxt.ovLock = 1'b1;
    end else if (s_r.lvl2 < lbbc_pkg::OV_RESTART_CODE) begin
      s_nxt.ovLock = 1'b0;
    end
    case (s_r.st)
      lbbc_pkg::LBBC_SENSE: begin
        s_nxt.cnt = s_r.cnt + 18'h00001;
        if (s_r.cnt == 18'(SENSE_CYCLES - 1)) begin
          s_nxt.cnt = 18'h00000;
          s_nxt.st  = lbbc_pkg::LBBC_PWRDLY;
          if (s_r.sel2 + 10'(lbbc_pkg::RATIO_TOL_PM) >=
              10'(lbbc_pkg::PM2) && s_r.sel2 <=
              10'(lbbc_pkg::PM2 + lbbc_pkg::RATIO_TOL_PM)) begin
            s_nxt.setting = lbbc_pkg::SETTING_2;
          end else if (s_r.sel2 + 10'(lbbc_pkg::RATIO_TOL_PM) >=
              10'(lbbc_pkg::PM3) && s_r.sel2 <=
              10'(lbbc_pkg::PM3 + lbbc_pkg::RATIO_TOL_PM)) begin
            s_nxt.setting = lbbc_pkg::SETTING_3;
          end else begin
            s_nxt.setting = lbbc_pkg::SETTING_1;
          end
        end
      end
      lbbc_pkg::LBBC_PWRDLY: begin
        if (tick) begin
          s_nxt.cnt = s_r.cnt + 18'h00001;
          if (s_r.cnt == 18'(PWRUP_TICKS - 1)) begin
            s_nxt.cnt = 18'h00000;
            s_nxt.st  = lbbc_pkg::LBBC_WAITLVL;
          end
        end
      end
      lbbc_pkg::LBBC_WAITLVL: begin
        if (s_r.levelOk && !s_r.ovLock && !s_r.cs2) begin
          s_nxt.st       = lbbc_pkg::LBBC_RUN;
          s_nxt.startup  = 1'b1;
          s_nxt.burstOff = 1'b0;
        end
      end
      lbbc_pkg::LBBC_RUN: begin
        if (!s_nxt.levelOk || s_nxt.ovLock || s_r.cs2) begin
          s_nxt.st  = lbbc_pkg::LBBC_RESTART;
          s_nxt.cnt = 18'h00000;
        end else if (s_r.startup) begin
          if ({1'b0, s_r.cmd2} < haltCmp) begin
            s_nxt.startup = 1'b0;
          end
        end else if ({1'b0, s_r.cmd2} >= haltCmp) begin
          s_nxt.burstOff = 1'b1;
        end else if ({1'b0, s_r.cmd2} <= resumeCmp) begin
          s_nxt.burstOff = 1'b0;
        end
      end
      lbbc_pkg::LBBC_RESTART: begin
        if (tick) begin
          s_nxt.cnt = s_r.cnt + 18'h00001;
          if (s_r.cnt == 18'(RESTART_TICKS - 1)) begin
            // off-state already held the pull-up; retry without extra delay
            s_nxt.cnt = 18'h00000;
            s_nxt.st  = lbbc_pkg::LBBC_WAITLVL;
          end
        end
      end
      default: begin
        s_nxt.st = lbbc_pkg::LBBC_SENSE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= lbbc_pkg::LBBC_SENSE;
      s_r.setting <= lbbc_pkg::SETTING_1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign bridgeEnable  = (s_r.st == lbbc_pkg::LBBC_RUN) &&
                         !s_r.burstOff;
  assign softStartPull = (s_r.st == lbbc_pkg::LBBC_PWRDLY) ||
                         (s_r.st == lbbc_pkg::LBBC_RESTART);
  assign selectSensing = (s_r.st == lbbc_pkg::LBBC_SENSE);
  assign burstSetting  = s_r.setting;
  assign topSwitchKhz  = s_r.topKhz;
  assign startupMode   = s_r.startup && (s_r.st == lbbc_pkg::LBBC_RUN);
  assign faultRestart  = (s_r.st == lbbc_pkg::LBBC_RESTART);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence runUnderLevel;
    s_r.st == lbbc_pkg::LBBC_RUN && s_r.lvl2 < lbbc_pkg::BROWNOUT_CODE;
  endsequence
  sequence runOverTrip;
    s_r.st == lbbc_pkg::LBBC_RUN && s_r.lvl2 > lbbc_pkg::OV_TRIP_CODE;
  endsequence

  brownin_gate_a: assert property (bridgeEnable |-> s_r.levelOk)
    else $error("switching without brown-in");
  ov_lockout_a: assert property (runOverTrip |=> !bridgeEnable[*2])
    else $error("switching above overvoltage trip");
  brownout_stop_a: assert property (runUnderLevel |=> faultRestart)
    else $error("no stop at brown-out");
  sense_window_a: assert property (
    (selectSensing && s_r.cnt == 18'(SENSE_CYCLES - 1))
      |=> !selectSensing && softStartPull)
    else $error("sense window length wrong");
  ratio_decode_a: assert property (
    (selectSensing && s_r.cnt == 18'(SENSE_CYCLES - 1) &&
     s_r.sel2 == 10'(lbbc_pkg::PM3)) |=> burstSetting == 2'h3)
    else $error("divider ratio decoded wrongly");
  setting_hold_a: assert property (
    (!selectSensing && !$past(selectSensing)) |-> $stable(burstSetting))
    else $error("burst setting changed in operation");
  fraction_pair_a: assert property (
    haltFrac16 == resumeFrac16 + 5'h01 &&
    haltFrac16 == 5'h09 - 5'({3'h0, burstSetting}))
    else $error("burst fractions wrong");
  burst_halt_a: assert property (
    (s_r.st == lbbc_pkg::LBBC_RUN && !s_r.startup && s_r.levelOk &&
     !s_r.ovLock && !s_r.cs2 && {1'b0, s_r.cmd2} >= haltCmp &&
     s_nxt.levelOk && !s_nxt.ovLock) |=> !bridgeEnable)
    else $error("no halt at halt frequency");
  startup_switch_a: assert property (startupMode |-> bridgeEnable)
    else $error("start-up mode not switching");
  tick_count_a: assert property (
    (softStartPull && !tick) |=> $stable(s_r.cnt))
    else $error("delay counter moved without tick");
  pwrup_hold_a: assert property (
    (s_r.st == lbbc_pkg::LBBC_PWRDLY && s_r.cnt < 18'(PWRUP_TICKS - 1))
      |=> softStartPull && !bridgeEnable)
    else $error("power-up delay cut short");
  restart_hold_a: assert property (
    (faultRestart && s_r.cnt < 18'(RESTART_TICKS - 1))
      |=> faultRestart)
    else $error("restart delay cut short");
endmodule : lbbc_top
`default_nettype wire

// *** tb_llc_burst_and_brownout_control.sv ***
// Purpose: self-checking bench for the burst and brown-out control
// Assumes: shortened counts; dead-time 300 ns gives 900 kHz ticks
// Notes:   stimulus moves 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_llc_burst_and_brownout_control;
  localparam int SC = 20;
  localparam int PT = 4;
  localparam int RT = 8;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  busLevel = 10'hf0;
  logic [9:0]  ratioPm = 10'h384;
  logic [9:0]  dtNs = 10'h12c;
  logic [7:0]  loopCmd = 8'hc8;
  logic        isFault = 1'b0;
  logic [9:0]  inputLevelCode, selectLevelPm, deadtimeNs;
  logic [7:0]  cmdFrac256;
  logic        currentFault, bridgeEnable, softStartPull, selectSensing;
  logic        startupMode, faultRestart;
  logic [1:0]  burstSetting;
  logic [10:0] topSwitchKhz;
  logic [4:0]  haltFrac16, resumeFrac16;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #50 clk_sys = ~clk_sys;

  lbbc_stage_model u_stage (.clk_sys(clk_sys), .selectSensing(selectSensing),
    .softStartPull(softStartPull), .busLevel(busLevel), .ratioPm(ratioPm),
    .dtNs(dtNs), .loopCmd(loopCmd), .isFault(isFault),
    .inputLevelCode(inputLevelCode), .selectLevelPm(selectLevelPm),
    .deadtimeNs(deadtimeNs), .cmdFrac256(cmdFrac256),
    .currentFault(currentFault));

  lbbc_top #(.SENSE_CYCLES(SC), .PWRUP_TICKS(PT), .RESTART_TICKS(RT)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .inputLevelCode(inputLevelCode),
    .selectLevelPm(selectLevelPm), .deadtimeNs(deadtimeNs),
    .cmdFrac256(cmdFrac256), .currentFault(currentFault),
    .bridgeEnable(bridgeEnable), .softStartPull(softStartPull),
    .selectSensing(selectSensing), .burstSetting(burstSetting),
    .topSwitchKhz(topSwitchKhz), .haltFrac16(haltFrac16),
    .resumeFrac16(resumeFrac16), .startupMode(startupMode),
    .faultRestart(faultRestart));

  // ==========================================================
  // shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // wait for bridgeEnable (sel 0) or faultRestart (sel 1) to reach v
  task automatic wt(input int sel, input logic v, input int lim);
    int   k;
    logic s;
    for (k = 0; k < lim; k++) begin
      s = (sel == 0) ? bridgeEnable : faultRestart;
      if (s === v) break;
      cyc(1);
    end
  endtask : wt

  task automatic doReset(input logic [9:0] pm);
    ratioPm = pm;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
  endtask : doReset

  // ==========================================================
  // scenarios
  task automatic t_settings();
    logic [9:0] pmTab [4];
    logic [1:0] expSet;
    int         i;
    pmTab = '{10'h3b6, 10'h384, 10'h352, 10'h2bc};
    for (i = 0; i < 4; i++) begin
      expSet = (i == 3) ? 2'h1 : 2'(i + 1);
      doReset(pmTab[i]);
      cyc(SC / 2);
      check(16'(selectSensing), 16'h1);
      check(16'(bridgeEnable), 16'h0);
      cyc(SC);
      check(16'(selectSensing), 16'h0);
      check(16'(burstSetting), 16'(expSet));
      check(16'(haltFrac16), 16'(5'h9 - 5'(expSet)));
      check(16'(resumeFrac16), 16'(5'h8 - 5'(expSet)));
      check(16'(softStartPull), 16'h1);
      check(16'(bridgeEnable), 16'h0);
    end
  endtask : t_settings

  task automatic t_brownin();
    busLevel = lbbc_pkg::BROWNIN_LVL - 10'h1;
    doReset(10'h384);
    wt(0, 1'b1, 400);
    check(16'(bridgeEnable), 16'h0);
    ratioPm = 10'h3b6;
    busLevel = lbbc_pkg::BROWNIN_LVL;
    wt(0, 1'b1, 60);
    check(16'(bridgeEnable), 16'h1);
    check(16'(startupMode), 16'h1);
    check(16'(softStartPull), 16'h0);
    check(16'(burstSetting), 16'h2);
  endtask : t_brownin

  task automatic t_frequency();
    int k;
    for (k = 0; k < 60 && topSwitchKhz !== 11'd900; k++) cyc(1);
    check(16'(topSwitchKhz), 16'd900);
    dtNs = 10'h113;
    for (k = 0; k < 60 && topSwitchKhz !== 11'd981; k++) cyc(1);
    check(16'(topSwitchKhz), 16'd981);
    dtNs = 10'h12c;
    for (k = 0; k < 60 && topSwitchKhz !== 11'd900; k++) cyc(1);
  endtask : t_frequency

  task automatic t_burst();
    loopCmd = 8'hc8;
    cyc(8);
    check(16'(bridgeEnable), 16'h1);
    check(16'(startupMode), 16'h1);
    loopCmd = 8'h6f;
    cyc(6);
    check(16'(startupMode), 16'h0);
    check(16'(bridgeEnable), 16'h1);
    loopCmd = 8'h70;
    cyc(6);
    check(16'(bridgeEnable), 16'h0);
    loopCmd = 8'h61;
    cyc(6);
    check(16'(bridgeEnable), 16'h0);
    loopCmd = 8'h60;
    cyc(6);
    check(16'(bridgeEnable), 16'h1);
  endtask : t_burst

  task automatic t_brownout();
    busLevel = lbbc_pkg::BROWNOUT_CODE;
    cyc(6);
    check(16'(bridgeEnable), 16'h1);
    busLevel = lbbc_pkg::BROWNOUT_CODE - 10'h1;
    cyc(5);
    check(16'(faultRestart), 16'h1);
    check(16'(bridgeEnable), 16'h0);
    check(16'(softStartPull), 16'h1);
    busLevel = lbbc_pkg::BROWNIN_LVL;
    cyc(70);
    check(16'(faultRestart), 16'h1);
    wt(1, 1'b0, 40);
    check(16'(faultRestart), 16'h0);
    check(16'(softStartPull), 16'h0);
    wt(0, 1'b1, 200);
    check(16'(bridgeEnable), 16'h1);
  endtask : t_brownout

  task automatic t_overvolt();
    busLevel = lbbc_pkg::OV_TRIP_CODE;
    cyc(6);
    check(16'(bridgeEnable), 16'h1);
    busLevel = lbbc_pkg::OV_TRIP_CODE + 10'h1;
    cyc(5);
    check(16'(faultRestart), 16'h1);
    busLevel = lbbc_pkg::OV_RESTART_CODE + 10'h1;
    wt(1, 1'b0, 200);
    wt(0, 1'b1, 150);
    check(16'(bridgeEnable), 16'h0);
    busLevel = lbbc_pkg::OV_RESTART_CODE - 10'h1;
    wt(0, 1'b1, 40);
    check(16'(bridgeEnable), 16'h1);
  endtask : t_overvolt

  task automatic t_current();
    isFault = 1'b1;
    cyc(5);
    check(16'(faultRestart), 16'h1);
    check(16'(bridgeEnable), 16'h0);
    isFault = 1'b0;
    wt(0, 1'b1, 400);
    check(16'(bridgeEnable), 16'h1);
  endtask : t_current

  // ==========================================================
  // run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    t_settings();
    t_brownin();
    t_frequency();
    t_burst();
    t_brownout();
    t_overvolt();
    t_current();
    conclude();
  end
endmodule : tb_llc_burst_and_brownout_control
`default_nettype wire
